/* bank_if.sv */
`timescale 1ns/100ps
interface bank_if #(parameter int N = 8);
  logic [N-1:0]       wr_unit;
  logic [7:0]         wr_idx;
  logic [7:0]         wr_data;
  logic [N-1:0]       link_wr;
  logic [N-1:0]       link_val;
  logic [N-1:0]       act;
  logic [N-1:0][15:0] base1;
  logic [N-1:0][15:0] base2;
  logic [N-1:0][3:0]  irq1;
  logic [N-1:0][3:0]  irq2;
  logic [N-1:0][2:0]  dma;
  modport ctrl (output wr_unit, wr_idx, wr_data, link_wr, link_val,
                input act, base1, base2, irq1, irq2, dma);
  modport store (input wr_unit, wr_idx, wr_data, link_wr, link_val,
                 output act, base1, base2, irq1, irq2, dma);
endinterface

/* bank_store.sv */
`timescale 1ns/100ps
module bank_store import cfg_bank_pkg::*; #(
  parameter int N = 8
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic init_req,
  bank_if.store     bus
);
  for (genvar u = 0; u < N; u++) begin : g_unit
    localparam logic [7:0] IRQ1_DFLT = (u == UNIT_FLOPPY) ? IRQ1_RST_U0 : IRQ1_RST;
    localparam logic [7:0] DMA_DFLT  = (u == UNIT_FLOPPY) ? DMA_RST_U0 :
                                       (u == UNIT_DMA_ALT) ? DMA_RST_ALT : DMA_RST;
    logic wr;
    assign wr = bus.wr_unit[u];
    // Activation follows host writes, else the linked power bit
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        bus.act[u] <= ACT_RST[ACT_BIT];
      end else if (init_req) begin
        bus.act[u] <= ACT_RST[ACT_BIT];
      end else if (wr && bus.wr_idx == IDX_ACT) begin
        bus.act[u] <= bus.wr_data[ACT_BIT];
      end else if (bus.link_wr[u]) begin
        bus.act[u] <= bus.link_val[u];
      end
    end
    // Base addresses, second pair only where the unit has one
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        bus.base1[u] <= {BASE_RST, BASE_RST};
        bus.base2[u] <= {BASE_RST, BASE_RST};
      end else if (init_req) begin
        bus.base1[u] <= {BASE_RST, BASE_RST};
        bus.base2[u] <= {BASE_RST, BASE_RST};
      end else if (wr) begin
        if (bus.wr_idx == IDX_BASE1_HI) bus.base1[u][15:8] <= bus.wr_data;
        if (bus.wr_idx == IDX_BASE1_LO) bus.base1[u][7:0] <= bus.wr_data;
        if (BASE2_UNITS[u] && bus.wr_idx == IDX_BASE2_HI) bus.base2[u][15:8] <= bus.wr_data;
        if (BASE2_UNITS[u] && bus.wr_idx == IDX_BASE2_LO) bus.base2[u][7:0] <= bus.wr_data;
      end
    end
    // Interrupt and DMA selects
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        bus.irq1[u] <= IRQ1_DFLT[IRQ_SEL_W-1:0];
        bus.irq2[u] <= IRQ2_RST[IRQ_SEL_W-1:0];
        bus.dma[u]  <= DMA_DFLT[DMA_SEL_W-1:0];
      end else if (init_req) begin
        bus.irq1[u] <= IRQ1_DFLT[IRQ_SEL_W-1:0];
        bus.irq2[u] <= IRQ2_RST[IRQ_SEL_W-1:0];
        bus.dma[u]  <= DMA_DFLT[DMA_SEL_W-1:0];
      end else if (wr) begin
        if (bus.wr_idx == IDX_IRQ1) bus.irq1[u] <= bus.wr_data[IRQ_SEL_W-1:0];
        if (u == UNIT_KBD && bus.wr_idx == IDX_IRQ2) bus.irq2[u] <= bus.wr_data[IRQ_SEL_W-1:0];
        if (DMA_UNITS[u] && bus.wr_idx == IDX_DMA) bus.dma[u] <= bus.wr_data[DMA_SEL_W-1:0];
      end
    end
  end
endmodule

/* cfg_bank_pkg.sv */
package cfg_bank_pkg;
  localparam int         MAX_UNITS       = 8;
  localparam int         ACT_BIT         = 0;
  localparam int         IRQ_SEL_W       = 4;
  localparam int         DMA_SEL_W       = 3;
  localparam int         UNIT_FLOPPY     = 0;
  localparam int         UNIT_PARALLEL   = 1;
  localparam int         UNIT_DMA_ALT    = 4;
  localparam int         UNIT_KBD        = 5;
  localparam logic [7:0] IDX_UNIT_SEL    = 8'h07;
  localparam logic [7:0] IDX_ACT         = 8'h30;
  localparam logic [7:0] IDX_CTL_FIRST   = 8'h31;
  localparam logic [7:0] IDX_MEM_LAST    = 8'h5F;
  localparam logic [7:0] IDX_BASE1_HI    = 8'h60;
  localparam logic [7:0] IDX_BASE1_LO    = 8'h61;
  localparam logic [7:0] IDX_BASE2_HI    = 8'h62;
  localparam logic [7:0] IDX_BASE2_LO    = 8'h63;
  localparam logic [7:0] IDX_IRQ1        = 8'h70;
  localparam logic [7:0] IDX_IRQ1_RSV    = 8'h71;
  localparam logic [7:0] IDX_IRQ2        = 8'h72;
  localparam logic [7:0] IDX_IRQ2_RSV    = 8'h73;
  localparam logic [7:0] IDX_DMA         = 8'h74;
  localparam logic [7:0] IDX_DMA_RSV     = 8'h75;
  localparam logic [7:0] IDX_LAST        = 8'hFF;
  localparam logic [7:0] ACT_RST         = 8'h00;
  localparam logic [7:0] BASE_RST        = 8'h00;
  localparam logic [7:0] IRQ1_RST        = 8'h00;
  localparam logic [7:0] IRQ1_RST_U0     = 8'h06;
  localparam logic [7:0] IRQ2_RST        = 8'h00;
  localparam logic [7:0] DMA_RST         = 8'h04;
  localparam logic [7:0] DMA_RST_U0      = 8'h02;
  localparam logic [7:0] DMA_RST_ALT     = 8'h04;
  localparam logic [2:0] DMA_FIRST_CH    = 3'h1;
  localparam logic [2:0] DMA_LAST_CH     = 3'h3;
  localparam logic [7:0] BASE2_UNITS     = 8'h02;
  localparam logic [7:0] DMA_UNITS       = 8'h13;
  localparam logic [15:0] BASE_MIN       = 16'h0100;
  localparam logic [15:0] BASE_MAX       = 16'h0FF8;
  localparam logic [15:0] ALIGN_FLOPPY   = 16'h0007;
  localparam logic [15:0] ALIGN_OTHER    = 16'h0003;
  localparam logic       IRQ_EDGE_DFLT   = 1'b1;
endpackage

/* host_port_model.sv */
`timescale 1ns/100ps
module host_port_model (
  input  wire logic       mclk,
  input  wire logic       read_valid_r,
  input  wire logic [7:0] read_data_r,
  output logic            index_wr,
  output logic            data_wr,
  output logic            data_rd,
  output logic [7:0]      host_wdata
);
  initial begin
    index_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    host_wdata = 8'h00;
  end

  // One strobe: raised after a falling edge, held over one rising edge
  task automatic strobe(input int kind, input logic [7:0] val, output logic [7:0] d,
                        output logic v);
    @(negedge mclk);
    index_wr <= (kind == 0);
    data_wr <= (kind == 1);
    data_rd <= (kind == 2);
    host_wdata <= val;
    @(negedge mclk);
    v = read_valid_r;
    d = read_data_r;
    index_wr <= 1'b0;
    data_wr <= 1'b0;
    data_rd <= 1'b0;
    host_wdata <= ~val;
  endtask

  // Index first, then the data port
  task automatic cfg_write(input logic [7:0] idx, input logic [7:0] val);
    logic [7:0] d;
    logic       v;
    strobe(0, idx, d, v);
    strobe(1, (idx == 8'h30) ? (val & 8'h01) : val, d, v);
  endtask
endmodule

/* logical_unit_config_bank.sv */
// Overview of operation
// - Unit-select at 0x07 picks the reached bank
// - Index port picks register, data port accesses
// - Bank access only in configuration state
// - Bit 0 of 0x30 activates unit
// - Unit on when activation or power set
// - Activation and power bits follow each other
// - Indices 0x31-0x5F ignore writes, read zero
// - 0x60 and 0x61 form primary base
// - 0x62 and 0x63 form second base
// - Unused base registers read zero, ignore writes
// - Out-of-range or misaligned primary base blocks unit decode
// - 0x70 everywhere, unit 0 resets 0x06
// - 0x72 works only in keyboard bank
// - Unit interrupts default edge, active high
// - 0x71, 0x73, 0x76-0xDF read zero
// - 0x74 only for floppy, parallel and unit 4
// - DMA select resets 0x02 unit 0, 0x04 unit 4
// - IRQ field bits 3:0, zero means none
// - DMA field bits 2:0, 0 and 4-7 mean none
`timescale 1ns/100ps
module logical_unit_config_bank import cfg_bank_pkg::*; #(
  parameter int NUM_UNITS = 8
) (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic                      init_req,
  input  wire logic                      cfg_state,
  input  wire logic                      index_wr,
  input  wire logic                      data_wr,
  input  wire logic                      data_rd,
  input  wire logic [7:0]                host_wdata,
  input  wire logic [NUM_UNITS-1:0]      power_bit,
  output logic      [7:0]                read_data_r,
  output logic                           read_valid_r,
  output logic      [7:0]                index_r,
  output logic      [7:0]                unit_sel_r,
  output logic      [NUM_UNITS-1:0]      unit_active_r,
  output logic      [NUM_UNITS-1:0]      decode_enable_r,
  output logic      [NUM_UNITS-1:0][15:0] primary_base,
  output logic      [NUM_UNITS-1:0][15:0] secondary_base,
  output logic      [NUM_UNITS-1:0][3:0] irq_line,
  output logic      [NUM_UNITS-1:0][3:0] irq_line_alt,
  output logic      [NUM_UNITS-1:0]      irq_enable_r,
  output logic      [NUM_UNITS-1:0]      irq_edge_high_r,
  output logic      [NUM_UNITS-1:0][2:0] dma_channel,
  output logic      [NUM_UNITS-1:0]      dma_enable_r,
  output logic      [NUM_UNITS-1:0]      power_link_wr_r,
  output logic      [NUM_UNITS-1:0]      power_link_val_r
);
  localparam int UW = $clog2(NUM_UNITS);

  if (NUM_UNITS < 2 || NUM_UNITS > MAX_UNITS) begin : g_bad_units
    $error("NUM_UNITS must lie between 2 and MAX_UNITS");
  end

  bank_if #(.N(NUM_UNITS)) bus ();

  logic [NUM_UNITS-1:0] power_prev_r;
  logic                 unit_ok;
  logic                 host_wr_ok;
  logic [UW-1:0]        sel_u;
  logic [7:0]           rd_mux;

  // Storage of every unit's bank
  bank_store #(.N(NUM_UNITS)) u_store (
    .mclk     (mclk),
    .reset    (reset),
    .init_req (init_req),
    .bus      (bus)
  );

  assign primary_base   = bus.base1;
  assign secondary_base = bus.base2;
  assign irq_line       = bus.irq1;
  assign irq_line_alt   = bus.irq2;
  assign dma_channel    = bus.dma;

  // Accesses only count inside the configuration state
  assign host_wr_ok = data_wr && cfg_state && !init_req;
  assign unit_ok    = unit_sel_r < 8'(NUM_UNITS);
  assign sel_u      = unit_sel_r[UW-1:0];

  // Index port latch
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      index_r <= 8'h00;
    end else if (init_req) begin
      index_r <= 8'h00;
    end else if (index_wr && cfg_state) begin
      index_r <= host_wdata;
    end
  end

  // Unit-select register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      unit_sel_r <= 8'h00;
    end else if (init_req) begin
      unit_sel_r <= 8'h00;
    end else if (host_wr_ok && index_r == IDX_UNIT_SEL) begin
      unit_sel_r <= host_wdata;
    end
  end

  // Route a data-port write to the selected bank only
  always_comb begin
    bus.wr_unit = '0;
    bus.wr_idx  = index_r;
    bus.wr_data = host_wdata;
    if (host_wr_ok && unit_ok) begin
      bus.wr_unit[sel_u] = 1'b1;
    end
  end

  // A change of the unit power bit drags the activation bit along
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      power_prev_r <= '0;
    end else begin
      power_prev_r <= power_bit;
    end
  end

  assign bus.link_wr  = power_bit ^ power_prev_r;
  assign bus.link_val = power_bit;

  // A host write to activation tells the power bit to follow
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      power_link_wr_r  <= '0;
      power_link_val_r <= '0;
    end else begin
      power_link_wr_r <= bus.wr_unit & {NUM_UNITS{index_r == IDX_ACT}};
      if (host_wr_ok && index_r == IDX_ACT) begin
        power_link_val_r <= {NUM_UNITS{host_wdata[ACT_BIT]}};
      end
    end
  end

  // Read multiplexer; anything not listed reads zero
  always_comb begin
    rd_mux = 8'h00;
    if (index_r == IDX_UNIT_SEL) begin
      rd_mux = unit_sel_r;
    end else if (unit_ok) begin
      case (index_r)
        IDX_ACT: begin
          rd_mux = {7'h00, bus.act[sel_u]};
        end
        IDX_BASE1_HI: begin
          rd_mux = bus.base1[sel_u][15:8];
        end
        IDX_BASE1_LO: begin
          rd_mux = bus.base1[sel_u][7:0];
        end
        IDX_BASE2_HI: begin
          rd_mux = BASE2_UNITS[sel_u] ? bus.base2[sel_u][15:8] : 8'h00;
        end
        IDX_BASE2_LO: begin
          rd_mux = BASE2_UNITS[sel_u] ? bus.base2[sel_u][7:0] : 8'h00;
        end
        IDX_IRQ1: begin
          rd_mux = {4'h0, bus.irq1[sel_u]};
        end
        IDX_IRQ2: begin
          rd_mux = (sel_u == UNIT_KBD[UW-1:0]) ? {4'h0, bus.irq2[sel_u]} : 8'h00;
        end
        IDX_DMA: begin
          rd_mux = DMA_UNITS[sel_u] ? {5'h00, bus.dma[sel_u]} : 8'h00;
        end
        default: begin
          rd_mux = 8'h00;
        end
      endcase
    end
  end

  // Data-port read answer, registered
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      read_data_r  <= 8'h00;
      read_valid_r <= 1'b0;
    end else begin
      read_valid_r <= data_rd && cfg_state && !init_req;
      if (data_rd && cfg_state && !init_req) begin
        read_data_r <= rd_mux;
      end
    end
  end

  // Per-unit status derived from the bank
  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_stat
    localparam logic [15:0] ALIGN = (u == UNIT_FLOPPY) ? ALIGN_FLOPPY : ALIGN_OTHER;
    logic base_ok;
    assign base_ok = bus.base1[u] >= BASE_MIN && bus.base1[u] <= BASE_MAX
                     && (bus.base1[u] & ALIGN) == 16'h0000;
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        unit_active_r[u]   <= 1'b0;
        decode_enable_r[u] <= 1'b0;
      end else begin
        unit_active_r[u]   <= bus.act[u] | power_bit[u];
        decode_enable_r[u] <= (bus.act[u] | power_bit[u]) && base_ok;
      end
    end
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        irq_enable_r[u]    <= 1'b0;
        dma_enable_r[u]    <= 1'b0;
        irq_edge_high_r[u] <= IRQ_EDGE_DFLT;
      end else begin
        irq_enable_r[u]    <= bus.irq1[u] != 4'h0;
        dma_enable_r[u]    <= DMA_UNITS[u] && bus.dma[u] >= DMA_FIRST_CH
                              && bus.dma[u] <= DMA_LAST_CH;
        irq_edge_high_r[u] <= IRQ_EDGE_DFLT;
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_read_at(logic [7:0] idx);
    data_rd && cfg_state && !init_req && index_r == idx;
  endsequence

  sequence s_write_at(logic [7:0] idx);
    data_wr && cfg_state && !init_req && index_r == idx;
  endsequence

  a_unit_route: assert property (
    s_write_at(IDX_ACT) ##0 unit_sel_r == 8'h00
    |=> bus.act[0] == $past(host_wdata[0]))
    else $error("activation write missed unit 0");

  a_index_hold: assert property (
    index_wr && cfg_state && !init_req |=> index_r == $past(host_wdata))
    else $error("index port not latched");

  a_cfg_gate: assert property (
    !cfg_state && !init_req |=> $stable(bus.base1) && !read_valid_r)
    else $error("bank changed outside configuration state");

  a_act_rsvd_bits: assert property (
    s_read_at(IDX_ACT) |=> read_valid_r && read_data_r[7:1] == 7'h00)
    else $error("activation reserved bits not zero");

  a_unit_on: assert property (
    ##1 unit_active_r == $past(bus.act | power_bit))
    else $error("unit active does not follow activation or power");

  a_act_link: assert property (
    s_write_at(IDX_ACT) ##0 unit_ok |=> power_link_wr_r != '0
    && power_link_val_r[0] == $past(host_wdata[0]))
    else $error("power bit not told of activation write");

  a_rsvd_range: assert property (
    data_rd && cfg_state && !init_req && index_r >= IDX_CTL_FIRST
    && index_r <= IDX_MEM_LAST |=> read_data_r == 8'h00)
    else $error("reserved control index read nonzero");

  a_base2_unused: assert property (
    s_read_at(IDX_BASE2_HI) ##0 unit_ok ##0 !BASE2_UNITS[sel_u]
    |=> read_data_r == 8'h00)
    else $error("unused second base reads nonzero");

  a_decode_range: assert property (
    decode_enable_r[0] |-> $past(bus.base1[0]) >= BASE_MIN
    && $past(bus.base1[0]) <= BASE_MAX)
    else $error("decode enabled with base out of range");

  a_irq2_gate: assert property (
    s_read_at(IDX_IRQ2) ##0 sel_u != UNIT_KBD[UW-1:0]
    |=> read_data_r == 8'h00)
    else $error("second interrupt select live outside keyboard");

  a_unimpl_zero: assert property (
    s_read_at(IDX_IRQ1_RSV) or s_read_at(IDX_DMA_RSV) or s_read_at(IDX_LAST)
    |=> read_data_r == 8'h00)
    else $error("unimplemented index reads nonzero");

  a_init_dflt: assert property (
    init_req |=> bus.irq1[0] == IRQ1_RST_U0[3:0] && bus.dma[0] == DMA_RST_U0[2:0]
    && bus.act == '0 ##1 !power_link_wr_r[0] [*2])
    else $error("bank defaults not restored");

  a_dma_none: assert property (
    dma_enable_r[0] |-> $past(bus.dma[0]) inside {[DMA_FIRST_CH:DMA_LAST_CH]})
    else $error("DMA enabled outside channels 1 to 3");

  a_irq_enable: assert property (
    s_write_at(IDX_IRQ1) ##0 unit_sel_r == 8'h00 ##0 host_wdata[3:0] == 4'h0
    |=> ##1 !irq_enable_r[0])
    else $error("zero interrupt select still enabled");

  a_base1_write: assert property (
    s_write_at(IDX_BASE1_HI) ##0 unit_sel_r == 8'h00
    |=> bus.base1[0][15:8] == $past(host_wdata))
    else $error("primary base high byte not written");

  a_base2_write: assert property (
    s_write_at(IDX_BASE2_LO) ##0 unit_sel_r == 8'(UNIT_PARALLEL)
    |=> bus.base2[UNIT_PARALLEL][7:0] == $past(host_wdata))
    else $error("second base low byte not written");

  a_base2_locked: assert property (
    s_write_at(IDX_BASE2_HI) ##0 unit_sel_r == 8'h00 |=> $stable(bus.base2[0]))
    else $error("unused second base took a write");

  a_unit_range: assert property (
    s_write_at(IDX_BASE1_HI) ##0 !unit_ok |=> $stable(bus.base1))
    else $error("write to missing unit reached a bank");

  a_read_answer: assert property (
    s_read_at(IDX_BASE1_LO) ##0 unit_sel_r == 8'h00
    |=> read_valid_r && read_data_r == $past(bus.base1[0][7:0]))
    else $error("read answer does not match selected register");

  a_act_read: assert property (
    s_read_at(IDX_ACT) ##0 unit_sel_r == 8'h00 |=> read_data_r[0] == $past(bus.act[0]))
    else $error("activation read does not match bank");

  a_irq_rsvd_bits: assert property (
    s_read_at(IDX_IRQ1) |=> read_data_r[7:4] == 4'h0)
    else $error("interrupt select reserved bits not zero");

  a_dma_rsvd_bits: assert property (
    s_read_at(IDX_DMA) |=> read_data_r[7:3] == 5'h00)
    else $error("DMA select reserved bits not zero");

  a_dma_gate: assert property (
    s_read_at(IDX_DMA) ##0 unit_ok ##0 !DMA_UNITS[sel_u] |=> read_data_r == 8'h00)
    else $error("DMA select live in a unit without DMA");

  a_other_dflt: assert property (
    init_req |=> bus.irq1[1] == IRQ1_RST[3:0] && bus.dma[UNIT_DMA_ALT] == DMA_RST_ALT[2:0])
    else $error("unit defaults not restored");

endmodule

/* logical_unit_config_bank_test.sv */
`timescale 1ns/100ps
module logical_unit_config_bank_test;
  import cfg_bank_pkg::*;
  logic             mclk;
  logic             reset;
  logic             init_req;
  logic             cfg_state;
  logic             index_wr;
  logic             data_wr;
  logic             data_rd;
  logic [7:0]       host_wdata;
  logic [7:0]       power_bit;
  logic [7:0]       read_data_r;
  logic             read_valid_r;
  logic [7:0]       unit_active_r;
  logic [7:0]       decode_enable_r;
  logic [7:0][15:0] primary_base;
  logic [7:0][3:0]  irq_line;
  logic [7:0]       irq_enable_r;
  logic [7:0]       irq_edge_high_r;
  logic [7:0]       dma_enable_r;
  logic [7:0]       index_r;
  logic [7:0]       unit_sel_r;
  logic [7:0][15:0] secondary_base;
  logic [7:0][3:0]  irq_line_alt;
  logic [7:0][2:0]  dma_channel;
  logic [7:0]       power_link_wr_r;
  logic [7:0]       power_link_val_r;
  int               error_cnt;
  int               samples_checked;
  int               cycles;
  int               usel;
  int               mem [8][256];
  int               idxs [18] = '{'h30, 'h31, 'h5F, 'h60, 'h61, 'h62, 'h63, 'h64, 'h6F,
                                  'h70, 'h71, 'h72, 'h73, 'h74, 'h75, 'h76, 'hDF, 'hFF};
  int               bases [5] = '{'h0100, 'h00FC, 'h0FF8, 'h1000, 'h0104};

  logical_unit_config_bank #(.NUM_UNITS(8)) dut_u (
    .mclk(mclk), .reset(reset), .init_req(init_req), .cfg_state(cfg_state),
    .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd), .host_wdata(host_wdata),
    .power_bit(power_bit), .read_data_r(read_data_r), .read_valid_r(read_valid_r),
    .index_r(index_r), .unit_sel_r(unit_sel_r), .unit_active_r(unit_active_r),
    .decode_enable_r(decode_enable_r), .primary_base(primary_base),
    .secondary_base(secondary_base), .irq_line(irq_line), .irq_line_alt(irq_line_alt),
    .irq_enable_r(irq_enable_r), .irq_edge_high_r(irq_edge_high_r),
    .dma_channel(dma_channel), .dma_enable_r(dma_enable_r),
    .power_link_wr_r(power_link_wr_r), .power_link_val_r(power_link_val_r)
  );

  host_port_model host_u (
    .mclk(mclk), .read_valid_r(read_valid_r), .read_data_r(read_data_r),
    .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd), .host_wdata(host_wdata)
  );

  always #2.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic model_reset();
    foreach (mem[u, i]) mem[u][i] = 0;
    mem[0]['h70] = 6;
    mem[0]['h74] = 2;
    mem[1]['h74] = 4;
    mem[4]['h74] = 4;
    usel = 0;
  endtask

  // Writable bits of each bank register, zero where writes are dropped
  function automatic int wmask(int u, int i);
    if (u > 7) return 0;
    case (i)
      'h30: return 1;
      'h60, 'h61: return 'hFF;
      'h62, 'h63: return (u == UNIT_PARALLEL) ? 'hFF : 0;
      'h70: return 'h0F;
      'h72: return (u == UNIT_KBD) ? 'h0F : 0;
      'h74: return (u inside {UNIT_FLOPPY, UNIT_PARALLEL, UNIT_DMA_ALT}) ? 'h07 : 0;
      default: return 0;
    endcase
  endfunction

  function automatic logic [7:0] exp_rd(int i);
    if (i == 7) return 8'(usel);
    if (usel > 7) return 8'h00;
    return 8'(mem[usel][i]);
  endfunction

  function automatic logic exp_dec(int u);
    int b;
    int al;
    b = mem[u]['h60] * 256 + mem[u]['h61];
    al = (u == UNIT_FLOPPY) ? int'(ALIGN_FLOPPY) : int'(ALIGN_OTHER);
    return (mem[u]['h30] != 0 || power_bit[u]) && b >= int'(BASE_MIN)
           && b <= int'(BASE_MAX) && (b & al) == 0;
  endfunction

  task automatic wr(input int i, input int d);
    int m;
    m = wmask(usel, i);
    host_u.cfg_write(8'(i), 8'(d));
    if (cfg_state && i == 7) usel = d & 'hFF;
    else if (cfg_state && m != 0) mem[usel][i] = d & m;
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input int i);
    logic [7:0] d;
    logic       v;
    host_u.strobe(0, 8'(i), d, v);
    host_u.strobe(2, 8'h00, d, v);
    chk_out({7'h00, v, d}, {8'h01, exp_rd(i)});
  endtask

  task automatic check_all();
    for (int u = 0; u < 8; u++) begin
      wr(7, u);
      foreach (idxs[k]) chk_rd(idxs[k]);
    end
    chk_out(16'(irq_edge_high_r), 16'h00FF);
  endtask

  initial begin
    logic [7:0] d;
    logic       v;
    int         u;
    int         i;
    int         dv;
    int         lw;
    int         ed;
    mclk = 1'b0;
    reset = 1'b1;
    init_req = 1'b0;
    cfg_state = 1'b1;
    power_bit = 8'h00;
    error_cnt = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(39846));
    model_reset();
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    for (int pass = 0; pass < 3; pass++) begin
      check_all();
      repeat (150) begin
        u = $urandom_range(0, 7);
        i = $urandom_range(0, 1) ? idxs[$urandom_range(0, 17)] : $urandom_range('h30, 'hFF);
        wr(7, u);
        dv = $urandom;
        wr(i, dv);
        lw = (i == 'h30) ? (1 << u) : 0;
        chk_out({power_link_wr_r, power_link_val_r & 8'(lw)}, {8'(lw), 8'((dv & 1) * lw)});
        chk_rd(i);
        chk_out({index_r, unit_sel_r}, {8'(i), 8'(usel)});
        chk_out(primary_base[u], 16'(mem[u]['h60] * 256 + mem[u]['h61]));
        chk_out(secondary_base[u], 16'(mem[u]['h62] * 256 + mem[u]['h63]));
        chk_out(16'(irq_line[u]), 16'(mem[u]['h70]));
        chk_out(16'(irq_line_alt[u]), 16'(mem[u]['h72]));
        ed = (wmask(u, 'h74) != 0) ? mem[u]['h74] : int'(DMA_RST);
        chk_out(16'(dma_channel[u]), 16'(ed));
        chk_out(16'(irq_enable_r[u]), 16'(mem[u]['h70] != 0));
        chk_out(16'(dma_enable_r[u]), 16'(mem[u]['h74] inside {1, 2, 3}));
        chk_out(16'(unit_active_r[u]), 16'(mem[u]['h30] != 0));
      end
      if (pass == 0) begin
        init_req = 1'b1;
        @(negedge mclk);
        init_req = 1'b0;
      end else begin
        reset = 1'b1;
        repeat (2) @(negedge mclk);
        reset = 1'b0;
      end
      model_reset();
    end
    cfg_state = 1'b0;
    wr('h60, 'hA5);
    host_u.strobe(2, 8'h00, d, v);
    chk_out(16'(v), 16'h0000);
    cfg_state = 1'b1;
    chk_rd('h60);
    wr(7, 9);
    chk_rd(7);
    wr('h60, 'h55);
    chk_rd('h60);
    wr(7, 3);
    power_bit[3] = 1'b1;
    mem[3]['h30] = 1;
    repeat (3) @(negedge mclk);
    chk_rd('h30);
    chk_out(16'(unit_active_r[3]), 16'h0001);
    power_bit[3] = 1'b0;
    mem[3]['h30] = 0;
    repeat (3) @(negedge mclk);
    chk_rd('h30);
    chk_out(16'(unit_active_r[3]), 16'h0000);
    foreach (bases[k]) begin
      for (int w = 0; w < 3; w += 2) begin
        wr(7, w);
        wr('h30, 1);
        wr('h60, bases[k] >> 8);
        wr('h61, bases[k]);
        repeat (3) @(negedge mclk);
        chk_out(16'(decode_enable_r[w]), 16'(exp_dec(w)));
      end
    end
    conclude();
  end
endmodule
